// File: csi_pkg.sv
/*
 * Shared constants and state types for the processor system-control link:
 * edge/level inputs, management-mode entry, stop-clock and bus hold.
 * Assumes both ends run on one 40 MHz clock (clk) with synchronous reset.
 */
// Summary of operation
// - interrupt request on rising edge only
// - source holds interrupt low four clocks first
// - soft reset resets all but base register and input synchronizers
// - soft reset held at least fifteen clocks
// - falling management edge enters mode after instruction
// - recognised at boundaries and string iterations
// - no split locked cycles, no nesting
// - one pending edge kept until resume
// - active output low from save to restore
// - stop request halts, drains, then grant cycle
// - stop request held until grant cycle seen
// - bus request driven whenever bus needed
// - hold waits for cycle end, then floats
// - hold kept while hold request stays high
// - acknowledge rises with float, always driven
package csi_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // minimum low time before a rising interrupt edge, in clock periods
    localparam int NMI_LOW_MIN_CLKS = 4;
    localparam int NMI_HIGH_CLKS = 2;
    localparam int SOFT_RESET_IN_MIN_CLKS = 15;
    localparam int SMI_LOW_CLKS = 2;
    localparam int CNT_W = 5;
    localparam logic [31:0] SYS_MGMT_BASE_RESET = 32'h0000_0000;

    // synchronizer bit positions
    localparam int SYNC_NMI = 0;
    localparam int SYNC_SRST = 1;
    localparam int SYNC_SMI = 2;
    localparam int SYNC_STOP = 3;
    localparam int SYNC_W = 4;
    // idle pin levels: stop and smi idle high
    localparam logic [3:0] SYNC_IDLE = 4'hc;

    typedef enum logic [1:0] {
        CSI_SMM_RUN = 2'b00,
        CSI_SMM_SAVE = 2'b01,
        CSI_SMM_ACTIVE = 2'b11,
        CSI_SMM_RESTORE = 2'b10
    } csi_smm_type;

    typedef enum logic [1:0] {
        CSI_STOP_IDLE = 2'b00,
        CSI_STOP_DRAIN = 2'b01,
        CSI_STOP_GRANT = 2'b11,
        CSI_STOP_HALTED = 2'b10
    } csi_stop_type;
endpackage

// File: csi_link_if.sv
/*
 * Pin-level link between the processor end and the system end.
 * Assumes one clock; all signals single-driver, no two-way pins.
 */
`timescale 1ns/1ps
interface csi_link_if;
    logic nmi;
    logic soft_reset_in;
    logic sys_mgmt_irq_n;
    logic sys_mgmt_active_n;
    logic clock_stop_request_n;
    logic stop_grant_cycle;
    logic internal_bus_request;
    logic hold_request;
    logic hold_acknowledge;
    logic bus_floated;

    modport cpu (
        input nmi,
        input soft_reset_in,
        input sys_mgmt_irq_n,
        output sys_mgmt_active_n,
        input clock_stop_request_n,
        output stop_grant_cycle,
        output internal_bus_request,
        input hold_request,
        output hold_acknowledge,
        output bus_floated
    );

    modport sys (
        output nmi,
        output soft_reset_in,
        output sys_mgmt_irq_n,
        input sys_mgmt_active_n,
        output clock_stop_request_n,
        input stop_grant_cycle,
        input internal_bus_request,
        output hold_request,
        input hold_acknowledge,
        input bus_floated
    );
endinterface

// File: csi_cpu_end.sv
/*
 * Processor end: synchronizes the asynchronous control inputs, raises
 * interrupt requests, sequences management-mode entry and exit, runs the
 * stop-clock drain and grant cycle, and arbitrates bus hold.
 * Assumes the core reports instruction boundaries, locked and active bus
 * cycles, save/restore progress and drain completion as plain signals.
 */
`timescale 1ns/1ps
module csi_cpu_end
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    csi_link_if.cpu link,
    input wire logic instr_boundary,
    input wire logic string_iteration,
    input wire logic locked_seq,
    input wire logic cycle_active,
    input wire logic core_bus_need,
    input wire logic nmi_taken,
    input wire logic save_done,
    input wire logic resume_from_sys_mgmt,
    input wire logic restore_last,
    input wire logic core_drained,
    input wire logic base_we,
    input wire logic [31:0] base_wdata,
    output logic core_reset,
    output logic nmi_request,
    output logic smm_entry,
    output logic sys_mgmt_mode,
    output logic core_halt,
    output logic core_bus_grant,
    output logic [31:0] sys_mgmt_base
);
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic nmi_prev_q;
    logic smi_prev_q;
    logic rst_int;
    logic nmi_rise;
    logic smi_fall;
    logic nmi_pending_q;
    logic smi_pending_q;
    logic smi_accept;
    logic stop_req;
    logic hold_enter;
    logic grant_issue;
    logic hold_ack_q;
    logic bus_req_q;
    logic active_n_q;
    logic grant_q;
    logic entry_q;
    logic [31:0] base_q;
    csi_smm_type smm_q;
    csi_smm_type smm_d;
    csi_stop_type stop_q;
    csi_stop_type stop_d;

    // first stage only feeds the second; everything else looks at sync2
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= {link.clock_stop_request_n, link.sys_mgmt_irq_n, link.soft_reset_in, link.nmi};
            sync2_q <= sync1_q;
        end
    end

    // soft reset clears everything except the base register and the input synchronizers
    assign rst_int = sys_rst | sync2_q[SYNC_SRST];
    assign core_reset = rst_int;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            base_q <= SYS_MGMT_BASE_RESET;
        end else if (base_we) begin
            base_q <= base_wdata;
        end
    end
    assign sys_mgmt_base = base_q;

    always_ff @(posedge clk) begin
        if (rst_int) begin
            nmi_prev_q <= 1'b0;
            smi_prev_q <= 1'b1;
        end else begin
            nmi_prev_q <= sync2_q[SYNC_NMI];
            smi_prev_q <= sync2_q[SYNC_SMI];
        end
    end

    // a held high level never re-arms; only a fresh low-to-high counts
    assign nmi_rise = sync2_q[SYNC_NMI] & ~nmi_prev_q;
    assign smi_fall = ~sync2_q[SYNC_SMI] & smi_prev_q;

    // new edge wins over the core's acknowledge in the same cycle
    always_ff @(posedge clk) begin
        if (rst_int) begin
            nmi_pending_q <= 1'b0;
        end else begin
            nmi_pending_q <= nmi_rise | (nmi_pending_q & ~nmi_taken);
        end
    end
    assign nmi_request = nmi_pending_q;

    // only outside management mode, at a boundary or string iteration, never inside a locked run
    assign smi_accept = smi_pending_q && smm_q == CSI_SMM_RUN && (instr_boundary || string_iteration)
        && !locked_seq;

    // a nested edge stays latched through the whole handler
    always_ff @(posedge clk) begin
        if (rst_int) begin
            smi_pending_q <= 1'b0;
        end else begin
            smi_pending_q <= smi_fall | (smi_pending_q & ~smi_accept);
        end
    end

    always_comb begin
        smm_d = smm_q;
        case (smm_q)
            CSI_SMM_RUN: begin
                if (smi_accept) begin
                    smm_d = CSI_SMM_SAVE;
                end
            end
            CSI_SMM_SAVE: begin
                if (save_done) begin
                    smm_d = CSI_SMM_ACTIVE;
                end
            end
            CSI_SMM_ACTIVE: begin
                if (resume_from_sys_mgmt) begin
                    smm_d = CSI_SMM_RESTORE;
                end
            end
            CSI_SMM_RESTORE: begin
                if (restore_last) begin
                    smm_d = CSI_SMM_RUN;
                end
            end
            default: begin
                smm_d = CSI_SMM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            smm_q <= CSI_SMM_RUN;
            active_n_q <= 1'b1;
            entry_q <= 1'b0;
        end else begin
            smm_q <= smm_d;
            active_n_q <= (smm_d == CSI_SMM_RUN);
            entry_q <= smi_accept;
        end
    end
    assign link.sys_mgmt_active_n = active_n_q;
    assign smm_entry = entry_q;
    assign sys_mgmt_mode = ~active_n_q;

    assign stop_req = ~sync2_q[SYNC_STOP];
    // grant cycle needs an owned, idle bus
    assign grant_issue = stop_q == CSI_STOP_GRANT && !hold_ack_q && !link.hold_request && !cycle_active;

    always_comb begin
        stop_d = stop_q;
        case (stop_q)
            CSI_STOP_IDLE: begin
                // pending interrupts and a management entry take precedence
                if (stop_req && instr_boundary && !nmi_pending_q && !smi_pending_q && smm_q == CSI_SMM_RUN) begin
                    stop_d = CSI_STOP_DRAIN;
                end
            end
            CSI_STOP_DRAIN: begin
                if (core_drained) begin
                    stop_d = CSI_STOP_GRANT;
                end
            end
            CSI_STOP_GRANT: begin
                if (grant_issue) begin
                    stop_d = CSI_STOP_HALTED;
                end
            end
            CSI_STOP_HALTED: begin
                // request may drop any time after the grant cycle
                if (!stop_req) begin
                    stop_d = CSI_STOP_IDLE;
                end
            end
            default: begin
                stop_d = CSI_STOP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            stop_q <= CSI_STOP_IDLE;
            grant_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
            grant_q <= grant_issue;
        end
    end
    assign link.stop_grant_cycle = grant_q;
    assign core_halt = (stop_q != CSI_STOP_IDLE);

    // request reflects internal need even while another master holds the bus
    always_ff @(posedge clk) begin
        if (rst_int) begin
            bus_req_q <= 1'b0;
        end else begin
            bus_req_q <= core_bus_need | (stop_q == CSI_STOP_GRANT);
        end
    end
    assign link.internal_bus_request = bus_req_q;

    // hold waits for the current cycle, burst or locked run to finish
    assign hold_enter = link.hold_request && !cycle_active && !locked_seq && !grant_issue;

    always_ff @(posedge clk) begin
        if (rst_int) begin
            hold_ack_q <= 1'b0;
        end else if (hold_ack_q) begin
            hold_ack_q <= link.hold_request;
        end else begin
            hold_ack_q <= hold_enter;
        end
    end
    // float and acknowledge come from one flop so they move together
    assign link.hold_acknowledge = hold_ack_q;
    assign link.bus_floated = hold_ack_q;

    // keeps the core from opening a new cycle while hold is being granted
    assign core_bus_grant = !hold_ack_q && !hold_enter;
endmodule

// File: csi_sys_end.sv
/*
 * System end: generates well-formed interrupt, soft reset, management
 * interrupt and stop-clock requests, and requests bus hold for an
 * alternate master. Assumes user-side fire strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
module csi_sys_end
    import csi_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    csi_link_if.sys link,
    input wire logic nmi_fire,
    input wire logic soft_reset_fire,
    input wire logic smi_fire,
    input wire logic stop_fire,
    input wire logic hold_want,
    output logic nmi_busy,
    output logic soft_reset_busy,
    output logic smi_busy,
    output logic stop_pending,
    output logic stop_granted,
    output logic hold_granted,
    output logic cpu_in_smm,
    output logic cpu_bus_request
);
    logic [CNT_W-1:0] nmi_cnt_q;
    logic nmi_q;
    logic [CNT_W-1:0] srst_cnt_q;
    logic srst_q;
    logic [CNT_W-1:0] smi_cnt_q;
    logic smi_n_q;
    logic stop_n_q;
    logic granted_q;
    logic hold_q;

    // counts low time while low, high time while high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_q <= 1'b0;
            nmi_cnt_q <= '0;
        end else if (nmi_q) begin
            if (nmi_cnt_q == CNT_W'(NMI_HIGH_CLKS - 1)) begin
                nmi_q <= 1'b0;
                nmi_cnt_q <= '0;
            end else begin
                nmi_cnt_q <= nmi_cnt_q + 1'b1;
            end
        end else if (nmi_fire && nmi_cnt_q >= CNT_W'(NMI_LOW_MIN_CLKS)) begin
            nmi_q <= 1'b1;
            nmi_cnt_q <= '0;
        end else if (nmi_cnt_q < CNT_W'(NMI_LOW_MIN_CLKS)) begin
            nmi_cnt_q <= nmi_cnt_q + 1'b1;
        end
    end
    assign link.nmi = nmi_q;
    // a fire while busy is dropped, not queued
    assign nmi_busy = nmi_q | (nmi_cnt_q < CNT_W'(NMI_LOW_MIN_CLKS));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srst_q <= 1'b0;
            srst_cnt_q <= '0;
        end else if (srst_q) begin
            if (srst_cnt_q == CNT_W'(SOFT_RESET_IN_MIN_CLKS - 1)) begin
                srst_q <= 1'b0;
            end
            srst_cnt_q <= srst_cnt_q + 1'b1;
        end else if (soft_reset_fire) begin
            srst_q <= 1'b1;
            srst_cnt_q <= '0;
        end
    end
    assign link.soft_reset_in = srst_q;
    assign soft_reset_busy = srst_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            smi_n_q <= 1'b1;
            smi_cnt_q <= '0;
        end else if (!smi_n_q) begin
            if (smi_cnt_q == CNT_W'(SMI_LOW_CLKS - 1)) begin
                smi_n_q <= 1'b1;
            end
            smi_cnt_q <= smi_cnt_q + 1'b1;
        end else if (smi_fire) begin
            smi_n_q <= 1'b0;
            smi_cnt_q <= '0;
        end
    end
    assign link.sys_mgmt_irq_n = smi_n_q;
    assign smi_busy = ~smi_n_q;

    // request stays low until the grant cycle is seen, then drops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stop_n_q <= 1'b1;
            granted_q <= 1'b0;
        end else if (!stop_n_q && link.stop_grant_cycle) begin
            stop_n_q <= 1'b1;
            granted_q <= 1'b1;
        end else if (stop_fire && stop_n_q) begin
            stop_n_q <= 1'b0;
            granted_q <= 1'b0;
        end
    end
    assign link.clock_stop_request_n = stop_n_q;
    assign stop_pending = ~stop_n_q;
    assign stop_granted = granted_q;

    // releasing hold_want lowers the request and ends bus hold
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_want;
        end
    end
    assign link.hold_request = hold_q;
    assign hold_granted = link.hold_acknowledge & hold_q;
    assign cpu_in_smm = ~link.sys_mgmt_active_n;
    assign cpu_bus_request = link.internal_bus_request;
endmodule

// File: csi_link_sva.sv
/*
 * Concurrent checks on the pins of the system-control link.
 * Assumes it is instantiated beside the link interface, with the shared clk and sys_rst.
 */
`timescale 1ns/1ps
module csi_link_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic nmi,
    input wire logic soft_reset_in,
    input wire logic clock_stop_request_n,
    input wire logic stop_grant_cycle,
    input wire logic internal_bus_request,
    input wire logic hold_request,
    input wire logic hold_acknowledge,
    input wire logic bus_floated
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_nmi_low_first;
        $rose(nmi) |-> !$past(nmi, 2) && !$past(nmi, 3) && !$past(nmi, 4);
    endproperty
    a_nmi_low_first: assert property (p_nmi_low_first)
        else $error("nmi rose without four low clocks");

    // fifteen cycles split in two runs to keep the unrolling small
    property p_srst_width;
        $rose(soft_reset_in) |-> soft_reset_in [*8] ##1 soft_reset_in [*7] ##1 !soft_reset_in;
    endproperty
    a_srst_width: assert property (p_srst_width)
        else $error("soft reset pulse is not fifteen clocks");

    property p_stop_held;
        !clock_stop_request_n && !stop_grant_cycle |=> !clock_stop_request_n;
    endproperty
    a_stop_held: assert property (p_stop_held)
        else $error("stop request released before grant cycle");

    property p_grant_needs_stop;
        stop_grant_cycle |-> !clock_stop_request_n && !hold_acknowledge;
    endproperty
    a_grant_needs_stop: assert property (p_grant_needs_stop)
        else $error("grant cycle without stop request or while held");

    property p_grant_pulse;
        stop_grant_cycle |=> !stop_grant_cycle;
    endproperty
    a_grant_pulse: assert property (p_grant_pulse)
        else $error("grant cycle longer than one clock");

    property p_grant_bus_req;
        stop_grant_cycle |-> internal_bus_request;
    endproperty
    a_grant_bus_req: assert property (p_grant_bus_req)
        else $error("grant cycle without bus request");

    property p_ack_float;
        hold_acknowledge == bus_floated;
    endproperty
    a_ack_float: assert property (p_ack_float)
        else $error("acknowledge and float differ");

    property p_ack_cause;
        $rose(hold_acknowledge) |-> $past(hold_request);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without hold request");

    property p_hold_stays;
        hold_acknowledge && hold_request |=> hold_acknowledge;
    endproperty
    a_hold_stays: assert property (p_hold_stays)
        else $error("hold left while still requested");

    property p_hold_drop;
        !hold_request |=> !hold_acknowledge;
    endproperty
    a_hold_drop: assert property (p_hold_drop)
        else $error("acknowledge kept after request dropped");
endmodule

// File: cpu_sysctl_interrupt_hold_bench.sv
/*
 * Self-checking bench: both link ends face each other, user sides driven here.
 * Assumes the link interface, both ends and the link checker are compiled first.
 */
`timescale 1ns/1ps
module cpu_sysctl_interrupt_hold_bench
    import csi_pkg::*;
;
    logic clk;
    logic sys_rst;
    logic [10:0] pul_q;
    logic [4:0] lvl_q;
    logic [31:0] wdata_q;
    logic core_reset, nmi_request, sys_mgmt_mode, core_halt, stop_granted;
    logic hold_granted, cpu_in_smm, cpu_bus_request, nmi_busy, smi_busy;
    logic smm_entry, core_bus_grant, soft_reset_busy, stop_pending;
    logic [31:0] sys_mgmt_base;
    logic [8:0] watch;
    int failures = 0;
    int check_count = 0;
    int n;
    localparam int NF = 0, SF = 1, MF = 2, TF = 3, BD = 4, ST = 5, NT = 6, SD = 7, RS = 8, RL = 9, BW = 10;
    localparam int LK = 0, CA = 1, BN = 2, DR = 3, HW = 4;

    csi_link_if link ();
    assign watch = {smi_busy, nmi_busy, link.nmi, core_reset, hold_granted, stop_granted, core_halt,
                    sys_mgmt_mode, nmi_request};

    csi_cpu_end u_csi_cpu_end (.clk(clk), .sys_rst(sys_rst), .link(link), .instr_boundary(pul_q[BD]),
        .string_iteration(pul_q[ST]), .locked_seq(lvl_q[LK]), .cycle_active(lvl_q[CA]),
        .core_bus_need(lvl_q[BN]), .nmi_taken(pul_q[NT]), .save_done(pul_q[SD]),
        .resume_from_sys_mgmt(pul_q[RS]), .restore_last(pul_q[RL]), .core_drained(lvl_q[DR]),
        .base_we(pul_q[BW]), .base_wdata(wdata_q), .core_reset(core_reset), .nmi_request(nmi_request),
        .smm_entry(smm_entry), .sys_mgmt_mode(sys_mgmt_mode), .core_halt(core_halt),
        .core_bus_grant(core_bus_grant),
        .sys_mgmt_base(sys_mgmt_base));
    csi_sys_end u_csi_sys_end (.clk(clk), .sys_rst(sys_rst), .link(link), .nmi_fire(pul_q[NF]),
        .soft_reset_fire(pul_q[SF]), .smi_fire(pul_q[MF]), .stop_fire(pul_q[TF]), .hold_want(lvl_q[HW]),
        .nmi_busy(nmi_busy), .soft_reset_busy(soft_reset_busy), .smi_busy(smi_busy),
        .stop_pending(stop_pending),
        .stop_granted(stop_granted), .hold_granted(hold_granted), .cpu_in_smm(cpu_in_smm),
        .cpu_bus_request(cpu_bus_request));
    csi_link_sva u_csi_link_sva (.clk(clk), .sys_rst(sys_rst), .nmi(link.nmi),
        .soft_reset_in(link.soft_reset_in), .clock_stop_request_n(link.clock_stop_request_n),
        .stop_grant_cycle(link.stop_grant_cycle), .internal_bus_request(link.internal_bus_request),
        .hold_request(link.hold_request), .hold_acknowledge(link.hold_acknowledge),
        .bus_floated(link.bus_floated));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // samples one step after the last of the k edges so the design has settled
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        pul_q[i] <= 1'b1;
        @(posedge clk);
        pul_q[i] <= 1'b0;
        #1;
    endtask

    task automatic set_level(input int i, input logic v);
        @(posedge clk);
        lvl_q[i] <= v;
        #1;
    endtask

    task automatic wait_for(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (watch[i] !== v && k < lim) begin
            cyc(1);
            k++;
        end
        if (watch[i] !== v) begin
            failures++;
            $display("Error at %0t: wait on %0d got %h expected %h", $time, i, watch[i], v);
            complete_run();
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        pul_q = 11'h000;
        lvl_q = 5'h00;
        wdata_q = 32'h0000_0000;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(1);
        check(sys_mgmt_base, SYS_MGMT_BASE_RESET, "base");

        wait_for(7, 1'b0, 10, n);
        pulse(NF);
        wait_for(6, 1'b1, 4, n);
        wait_for(0, 1'b1, 10, n);
        check(32'(n), 32'h3, "nmi latency");
        pulse(NT);
        cyc(10);
        check(nmi_request, 1'b0, "nmi once");
        $display("test nmi done");

        set_level(LK, 1'b1);
        pulse(MF);
        cyc(5);
        pulse(BD);
        cyc(2);
        check(sys_mgmt_mode, 1'b0, "locked smi");
        set_level(LK, 1'b0);
        pulse(ST);
        wait_for(1, 1'b1, 4, n);
        check(cpu_in_smm, 1'b1, "smm entry");
        check(smm_entry, 1'b1, "entry pulse");
        wait_for(8, 1'b0, 20, n);
        pulse(MF);
        cyc(5);
        pulse(BD);
        pulse(SD);
        pulse(RS);
        cyc(2);
        check(link.sys_mgmt_active_n, 1'b0, "restore low");
        pulse(RL);
        cyc(2);
        check(link.sys_mgmt_active_n, 1'b1, "smm exit");
        pulse(BD);
        wait_for(1, 1'b1, 4, n);
        check(cpu_in_smm, 1'b1, "nested smi");
        pulse(SD);
        pulse(RS);
        pulse(RL);
        cyc(2);
        check(sys_mgmt_mode, 1'b0, "second exit");
        $display("test smi done");

        pulse(TF);
        cyc(3);
        pulse(BD);
        wait_for(2, 1'b1, 4, n);
        cyc(5);
        check(stop_granted, 1'b0, "grant before drain");
        check(stop_pending, 1'b1, "stop held");
        set_level(DR, 1'b1);
        wait_for(3, 1'b1, 20, n);
        check(core_halt, 1'b1, "halted at grant");
        wait_for(2, 1'b0, 20, n);
        check(link.clock_stop_request_n, 1'b1, "stop released");
        set_level(DR, 1'b0);
        $display("test stop done");

        // an active cycle must hold off the acknowledge
        set_level(CA, 1'b1);
        set_level(HW, 1'b1);
        cyc(6);
        check(link.hold_acknowledge, 1'b0, "hold in cycle");
        check(core_bus_grant, 1'b1, "core keeps bus");
        set_level(CA, 1'b0);
        wait_for(4, 1'b1, 6, n);
        check(link.bus_floated, 1'b1, "float");
        check(core_bus_grant, 1'b0, "core off bus");
        set_level(BN, 1'b1);
        cyc(10);
        check(link.hold_acknowledge, 1'b1, "hold kept");
        check(cpu_bus_request, 1'b1, "request in hold");
        set_level(HW, 1'b0);
        cyc(3);
        check(link.hold_acknowledge, 1'b0, "hold left");
        set_level(BN, 1'b0);
        cyc(3);
        check(link.internal_bus_request, 1'b0, "request idle");
        $display("test hold done");

        wdata_q <= 32'h1234_5678;
        pulse(BW);
        wait_for(7, 1'b0, 10, n);
        pulse(NF);
        wait_for(0, 1'b1, 10, n);
        pulse(SF);
        wait_for(5, 1'b1, 6, n);
        check(soft_reset_busy, 1'b1, "soft reset busy");
        wait_for(5, 1'b0, 40, n);
        check(32'(n), 32'(SOFT_RESET_IN_MIN_CLKS), "soft reset width");
        check(sys_mgmt_base, 32'h1234_5678, "base kept");
        check(nmi_request, 1'b0, "nmi cleared");
        $display("test soft reset done");
        complete_run();
    end
endmodule
